// File: logic/dpr_ctrl.sv
// host-side sequencer for a 4-bank asynchronous x16 dram system
// assumes synchronous request signals and one 100 ns clock
`timescale 1ns/1ps
module dpr_ctrl (
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   srst_i,
  // user requests
  input  wire logic                   req_valid_i,
  input  wire dpr_pkg::dpr_req_t      req_i,
  output logic                        req_ready_o,
  output logic                        ready_o,
  output logic [dpr_pkg::DATA_W-1:0]  rdata_o,
  output logic                        rdata_valid_o,
  input  wire logic                   refresh_req_i,
  output logic                        refresh_done_o,
  // dram pins
  output dpr_pkg::dpr_strobe_t        mem_o,
  input  wire logic [dpr_pkg::DATA_W-1:0] dq_i,
  output logic [dpr_pkg::DATA_W-1:0]  dq_o,
  output logic                        dq_oe_o
);
  import dpr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dpr_state_t        st_reg, st_next;
  logic [3:0]        wake_reg, wake_next;
  dpr_req_t          cur_reg, cur_next;
  dpr_strobe_t       mem_reg, mem_next;
  logic [DATA_W-1:0] rd_reg, rd_next;
  logic              rv_reg, rv_next;
  logic              rfd_reg, rfd_next;
  logic              ph_load;
  logic              ph_zero;
  logic              pw_zero;
  logic              pw_load;
  logic              pw_done_reg, pw_done_next;

  // power-up delay counter, loaded once at reset release
  dpr_cnt #(.W(10)) u_pw (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .load_i     (pw_load),
    .value_i    (10'(PWRUP_CYC)),
    .zero_o     (pw_zero)
  );

  dpr_cnt #(.W(2)) u_ph (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .load_i     (ph_load),
    .value_i    (PH_CNT),
    .zero_o     (ph_zero)
  );

  logic started_reg, started_next;
  assign pw_load = !started_reg;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_next      = st_reg;
    wake_next    = wake_reg;
    cur_next     = cur_reg;
    mem_next     = mem_reg;
    rd_next      = rd_reg;
    rv_next      = 1'b0;
    rfd_next     = 1'b0;
    ph_load      = 1'b0;
    started_next = 1'b1;
    pw_done_next = pw_done_reg;
    // write strobes always move together, never separately [R14]
    // early write only: oe stays high on writes, no bit mask [R12]
    // no byte lanes and no mask loading: whole words only [R15]
    case (st_reg)
      DPR_POWER: begin
        if (started_reg && pw_zero) begin // [R04]
          pw_done_next = 1'b1;
          // wake-up uses column-before-row refresh with write high,
          // which also pulls a part out of test mode [R05] [R06] [R07]
          mem_next.cas_n = 1'b0;
          mem_next.we_n  = 2'b11; // [R02]
          ph_load        = 1'b1;
          st_next        = DPR_WK_CAS;
        end
      end
      DPR_WK_CAS: begin
        if (ph_zero) begin
          mem_next.ras_n = '0;
          ph_load        = 1'b1;
          st_next        = DPR_WK_RAS;
        end
      end
      DPR_WK_RAS: begin
        if (ph_zero) begin
          mem_next.ras_n = '1;
          mem_next.cas_n = 1'b1;
          wake_next      = wake_reg + 4'h1;
          ph_load        = 1'b1;
          st_next        = DPR_WK_PRE;
        end
      end
      DPR_WK_PRE: begin
        if (ph_zero) begin
          if (wake_reg == WAKE_CNT) begin // [R04]
            st_next = DPR_IDLE;
          end else begin
            mem_next.cas_n = 1'b0;
            ph_load        = 1'b1;
            st_next        = DPR_WK_CAS;
          end
        end
      end
      DPR_IDLE: begin
        if (refresh_req_i) begin
          mem_next.cas_n = 1'b0;
          mem_next.we_n  = 2'b11; // [R02]
          ph_load        = 1'b1;
          st_next        = DPR_RF_CAS;
        end else if (req_valid_i) begin // [R17]
          cur_next = req_i;
          // write held high at the row fall: no masked cycle [R13]
          mem_next.we_n  = 2'b11;
          mem_next.addr  = req_i.addr[2*ROW_W-1:ROW_W];
          mem_next.ras_n = ~(BANKS'(1) << req_i.addr[ADDR_W-1 -: 2]); // [R16]
          ph_load        = 1'b1;
          st_next        = DPR_ROW;
        end
      end
      DPR_ROW: begin
        if (ph_zero) begin
          mem_next.addr  = cur_reg.addr[ROW_W-1:0];
          mem_next.we_n  = cur_reg.write ? 2'b00 : 2'b11; // [R14]
          mem_next.oe_n  = cur_reg.write; // [R16]
          mem_next.cas_n = 1'b0;
          ph_load        = 1'b1;
          st_next        = DPR_COL;
        end
      end
      DPR_COL: begin
        if (ph_zero) begin
          if (!cur_reg.write) begin
            rd_next = dq_i;
            rv_next = 1'b1;
          end
          mem_next.ras_n = '1;
          mem_next.cas_n = 1'b1;
          mem_next.we_n  = 2'b11;
          mem_next.oe_n  = 1'b1;
          ph_load        = 1'b1;
          st_next        = DPR_PRE;
        end
      end
      DPR_RF_CAS: begin
        if (ph_zero) begin
          mem_next.ras_n = '0;
          ph_load        = 1'b1;
          st_next        = DPR_RF_RAS;
        end
      end
      DPR_RF_RAS: begin
        if (ph_zero) begin
          mem_next.ras_n = '1;
          mem_next.cas_n = 1'b1;
          rfd_next       = 1'b1;
          ph_load        = 1'b1;
          st_next        = DPR_PRE;
        end
      end
      DPR_PRE: begin
        if (ph_zero) begin
          st_next = DPR_IDLE;
        end
      end
      default: begin
        st_next = DPR_POWER;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_reg      <= DPR_POWER;
      wake_reg    <= 4'h0;
      cur_reg     <= '0;
      mem_reg     <= '{ras_n: '1, cas_n: 1'b1, we_n: 2'b11, oe_n: 1'b1,
                       addr: '0};
      rd_reg      <= '0;
      rv_reg      <= 1'b0;
      rfd_reg     <= 1'b0;
      started_reg <= 1'b0;
      pw_done_reg <= 1'b0;
    end else begin
      st_reg      <= st_next;
      wake_reg    <= wake_next;
      cur_reg     <= cur_next;
      mem_reg     <= mem_next;
      rd_reg      <= rd_next;
      rv_reg      <= rv_next;
      rfd_reg     <= rfd_next;
      started_reg <= started_next;
      pw_done_reg <= pw_done_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // refresh has priority, so a request waits while one is pending
  assign ready_o        = (st_reg == DPR_IDLE) && pw_done_reg; // [R17]
  assign req_ready_o    = ready_o && !refresh_req_i;
  assign rdata_o        = rd_reg;
  assign rdata_valid_o  = rv_reg;
  assign refresh_done_o = rfd_reg;
  assign mem_o          = mem_reg;
  assign dq_o           = cur_reg.wdata;
  assign dq_oe_o        = cur_reg.write &&
                          (st_reg == DPR_ROW || st_reg == DPR_COL);
endmodule : dpr_ctrl

// File: logic/dpr_pkg.sv
// package for the dram power-up and refresh strobe controller
// assumes a single 10 MHz core clock and synchronous active-high reset
// Functional notes
// [R01] older 1M part: refresh ignores write strobe
// [R02] 4M part: write strobe high during refresh
// [R03] 4M part: refresh with write low enters test
// [R04] 1M part: wait 100us, then eight row cycles
// [R05] 4M wake-up: row-only or refresh, write high
// [R06] 4M part may power up in test mode
// [R07] test mode exits on row-only or refresh
// [R08] dual-strobe x16: byte writes, no bit mask
// [R09] single-strobe x16: per-bit mask, not persistent
// [R10] single-strobe: write low at row fall masks
// [R11] dual-strobe ignores write level at row fall
// [R12] controller uses no byte or masked writes
// [R13] write strobe high at every row fall
// [R14] both write strobes driven as one
// [R15] byte writes by mask loading: not used
// [R16] four row strobes select banks, early write
// [R17] requests blocked until power-up completes
package dpr_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int PWRUP_DELAY_US   = 100;
  localparam int PWRUP_CYC        =
    (PWRUP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES      = 8;
  localparam int PH_CYC           = 2;
  localparam logic [3:0] WAKE_CNT = 4'h8;
  localparam logic [1:0] PH_CNT   = 2'h2;

  localparam int ADDR_W = 18;
  localparam int ROW_W  = 8;
  localparam int DATA_W = 16;
  localparam int BANKS  = 4;

  typedef enum logic [3:0] {
    DPR_POWER   = 4'b0000,
    DPR_WK_CAS  = 4'b0001,
    DPR_WK_RAS  = 4'b0010,
    DPR_WK_PRE  = 4'b0011,
    DPR_IDLE    = 4'b0100,
    DPR_ROW     = 4'b0101,
    DPR_COL     = 4'b0110,
    DPR_PRE     = 4'b0111,
    DPR_RF_CAS  = 4'b1000,
    DPR_RF_RAS  = 4'b1001
  } dpr_state_t;

  // strobes toward the memory, all active low
  typedef struct packed {
    logic [BANKS-1:0] ras_n;
    logic             cas_n;
    logic [1:0]       we_n;
    logic             oe_n;
    logic [ROW_W-1:0] addr;
  } dpr_strobe_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpr_req_t;

endpackage : dpr_pkg

// File: logic/dpr_cnt.sv
// down counter used for the power-up delay and strobe phases
// assumes synchronous reset; load wins over counting
`timescale 1ns/1ps
module dpr_cnt #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  // control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  // status
  output logic              zero_o
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = value_i;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign zero_o = (cnt_reg == '0);
endmodule : dpr_cnt

// File: tb/dpr_ctrl_assertions.sv
// checker for the dram strobe sequencer, bound onto dpr_ctrl
// assumes the port names and walk of dpr_ctrl, one clock domain
`timescale 1ns/1ps
module dpr_ctrl_assertions
  import dpr_pkg::*;
(
  // watched ports
  input wire logic                 core_clk_i,
  input wire logic                 srst_i,
  input wire logic                 req_valid_i,
  input wire dpr_pkg::dpr_req_t    req_i,
  input wire logic                 req_ready_o,
  input wire logic                 ready_o,
  input wire logic                 rdata_valid_o,
  input wire logic                 refresh_req_i,
  input wire logic                 refresh_done_o,
  input wire dpr_pkg::dpr_strobe_t mem_o
);
  logic [10:0] cyc_reg, cyc_next;
  logic [3:0]  cbr_reg, cbr_next;
  logic        cas_reg, up_reg, up_next, cbr_fall;
  always_comb begin
    cbr_fall = cas_reg && !mem_o.cas_n && &mem_o.ras_n;
    cyc_next = (cyc_reg == 11'h7FF) ? cyc_reg : cyc_reg + 11'h1;
    cbr_next = cbr_reg + {3'h0, cbr_fall};
    up_next  = up_reg | ready_o;
  end
  always_ff @(posedge core_clk_i) begin
    cyc_reg <= srst_i ? 11'h0 : cyc_next;
    cbr_reg <= srst_i ? 4'h0 : cbr_next;
    up_reg  <= srst_i ? 1'b0 : up_next;
    cas_reg <= srst_i ? 1'b1 : mem_o.cas_n;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  sequence rf_take; ready_o && refresh_req_i; endsequence
  sequence rd_take; req_valid_i && req_ready_o && !req_i.write; endsequence
  sequence cbr_start; $fell(mem_o.cas_n) && &mem_o.ras_n; endsequence
  reset_idle_a: assert property ($fell(srst_i) |->
    &mem_o.ras_n && mem_o.cas_n && !ready_o) else $error("not idle");
  we_paired_a: assert property (mem_o.we_n[0] == mem_o.we_n[1])
    else $error("write strobes split");
  we_row_fall_a: assert property (|($past(mem_o.ras_n) & ~mem_o.ras_n)
    |-> &mem_o.we_n) else $error("write low at row fall");
  cbr_we_high_a: assert property (cbr_start |-> &mem_o.we_n [*8])
    else $error("write low in refresh");
  pwrup_wait_a: assert property (cbr_fall && !up_reg
    |-> cyc_reg >= 11'(PWRUP_CYC)) else $error("wake cycle too early");
  wake_count_a: assert property ($rose(ready_o) && !up_reg
    |-> cbr_reg == WAKE_CNT) else $error("wrong wake cycle count");
  wake_cbr_a: assert property (!up_reg && !(&mem_o.ras_n)
    |-> !mem_o.cas_n) else $error("wake cycle not a refresh");
  ready_gate_a: assert property (req_ready_o |->
    &mem_o.ras_n && mem_o.cas_n && &mem_o.we_n)
    else $error("request offered while busy");
  rf_done_a: assert property (rf_take |-> ##[4:12] refresh_done_o)
    else $error("refresh not done");
  rd_answer_a: assert property (rd_take |-> ##[4:12] rdata_valid_o)
    else $error("read not answered");
  oe_no_write_a: assert property (!mem_o.oe_n |-> &mem_o.we_n)
    else $error("output enable during write");
endmodule : dpr_ctrl_assertions

bind dpr_ctrl dpr_ctrl_assertions u_chk (.core_clk_i(core_clk_i),
  .srst_i(srst_i), .req_valid_i(req_valid_i), .req_i(req_i),
  .req_ready_o(req_ready_o), .ready_o(ready_o),
  .rdata_valid_o(rdata_valid_o), .refresh_req_i(refresh_req_i),
  .refresh_done_o(refresh_done_o), .mem_o(mem_o));

// File: tb/dpr_dram_model.sv
// behavioural 4-bank x16 dram with a write-low test mode
// assumes strobes straight from dpr_ctrl, all active low
`timescale 1ns/1ps
module dpr_dram_model
  import dpr_pkg::*;
#(
  // older part: refresh ignores the write strobe, no strobe test mode
  parameter bit OLD_GEN = 1'b0,
  // two write strobes with one byte lane each, no bit mask
  parameter bit DUAL_WE = 1'b0
) (
  // strobes and data
  input  wire dpr_pkg::dpr_strobe_t       mem_i,
  input  wire logic [dpr_pkg::DATA_W-1:0] wdata_i,
  output logic [dpr_pkg::DATA_W-1:0]      rdata_o,
  // observation
  output logic                            test_o,
  output logic                            mask_o,
  output logic [7:0]                      nref_o
);
  logic [15:0] arr [int];
  logic [15:0] rd = 16'h0;
  int          row;
  int          key;
  logic [15:0] wr;
  wire         ras_up = &mem_i.ras_n;
  // parts may wake up in test mode
  initial test_o = 1'b1;
  initial mask_o = 1'b0;
  initial nref_o = 8'h0;
  // released bus shows the inverse, never the last value
  assign rdata_o = (!mem_i.cas_n && !mem_i.oe_n) ? rd : ~rd;
  always @(negedge ras_up) begin
    row = 0;
    for (int b = 0; b < BANKS; b++)
      if (!mem_i.ras_n[b]) row = b;
    row = (row << 8) | mem_i.addr;
    if (!mem_i.cas_n) begin
      if (!OLD_GEN)
        test_o = !mem_i.we_n[0];
      nref_o = nref_o + 8'h1;
    end else if (!mem_i.we_n[0] && !DUAL_WE)
      mask_o = 1'b1;
  end
  always @(negedge mem_i.cas_n) begin
    #1;
    key = (row << 8) | mem_i.addr;
    wr  = arr.exists(key) ? arr[key] : 16'h0;
    if (!ras_up && DUAL_WE) begin
      // each write strobe guards its own byte lane
      for (int b = 0; b < 2; b++)
        if (!mem_i.we_n[b]) wr[8*b +: 8] = wdata_i[8*b +: 8];
    end else if (!ras_up && !mem_i.we_n[0])
      wr = wdata_i;
    if (!ras_up && !(&mem_i.we_n))
      arr[key] = wr;
    else if (!ras_up)
      rd = arr.exists(key) ? arr[key] : ~rd;
  end
endmodule : dpr_dram_model

// File: tb/dpr_ctrl_tb_top.sv
// self-checking bench for dpr_ctrl against a behavioural dram
// assumes dpr_pkg types and a 100 ns core clock
`timescale 1ns/1ps
module dpr_ctrl_tb_top;
  import dpr_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, valid = 1'b0, rf_req = 1'b0;
  dpr_req_t    req = '0;
  logic        req_ready, ready, rvalid, rf_done, dq_oe, test, mask;
  logic [15:0] rdata, dq_rd, dq_wr;
  logic [7:0]  nref;
  dpr_strobe_t mem;
  int          n_errors = 0, n_compared = 0;
  initial forever #50 clk = ~clk;
  dpr_ctrl DUT (.core_clk_i(clk), .srst_i(srst), .req_valid_i(valid),
    .req_i(req), .req_ready_o(req_ready), .ready_o(ready),
    .rdata_o(rdata), .rdata_valid_o(rvalid), .refresh_req_i(rf_req),
    .refresh_done_o(rf_done), .mem_o(mem), .dq_i(dq_rd), .dq_o(dq_wr),
    .dq_oe_o(dq_oe));
  dpr_dram_model u_dram (.mem_i(mem), .wdata_i(dq_wr), .rdata_o(dq_rd),
    .test_o(test), .mask_o(mask), .nref_o(nref));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic waitfor(ref logic s);
    int n = 0;
    while (s !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n < 40), 16'h1);
  endtask : waitfor
  task automatic access(input logic w, input logic [17:0] a,
                        input logic [15:0] d);
    valid = 1'b1;
    req = '{w, a, d};
    waitfor(req_ready);
    @(negedge clk);
    valid = 1'b0;
    chk(16'(dq_oe), 16'(w));
    if (!w) waitfor(rvalid);
    if (!w) chk(rdata, d);
    waitfor(ready);
  endtask : access
  task automatic t_powerup;
    int n = 0;
    logic bad = 1'b0;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    valid = 1'b1;
    req = '{1'b1, 18'h1_00_01, 16'hFFFF};
    while (ready !== 1'b1 && n < 3000) begin
      bad = bad | req_ready;
      @(negedge clk);
      n++;
    end
    valid = 1'b0;
    @(negedge clk);
    chk(16'(bad), 16'h0);
    chk(16'(n >= PWRUP_CYC + WAKE_CYCLES && n < 3000), 16'h1);
    chk({8'h0, nref}, 16'(WAKE_CYCLES));
    chk(16'(test), 16'h0);
  endtask : t_powerup
  task automatic t_rw;
    access(1'b1, 18'h3_12_34, 16'hA5C3);
    access(1'b1, 18'h0_12_34, 16'h5A3C);
    access(1'b0, 18'h3_12_34, 16'hA5C3);
    access(1'b0, 18'h0_12_34, 16'h5A3C);
    chk(16'(mask), 16'h0);
  endtask : t_rw
  task automatic t_refresh;
    logic [7:0] n0 = nref;
    rf_req = 1'b1;
    valid = 1'b1;
    req = '{1'b0, 18'h3_12_34, 16'h0};
    #1 chk(16'(req_ready), 16'h0);
    @(negedge clk);
    rf_req = 1'b0;
    valid = 1'b0;
    waitfor(rf_done);
    chk({8'h0, nref - n0}, 16'h1);
    chk(16'(test), 16'h0);
    waitfor(ready);
    access(1'b0, 18'h3_12_34, 16'hA5C3);
  endtask : t_refresh
  initial begin
    #(4000 * 100);
    n_errors++;
    end_of_test();
  end
  initial begin
    @(negedge clk);
    t_powerup();
    t_rw();
    t_refresh();
    end_of_test();
  end
endmodule : dpr_ctrl_tb_top
